// ==== rtl/pabt_pkg.sv ====
`default_nettype none
package pabt_pkg;
  // ----------------------------------------------------------------
  // host port map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_DATA = 2'h3;
  localparam logic [7:0] IDLE_READ = 8'h80;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // status bit positions
  localparam int ST_CAP_HALF = 7;
  localparam int ST_CAP_SIDE = 6;
  localparam int ST_CAP_RDY = 5;
  localparam int ST_SER = 4;
  localparam int ST_PB_HALF = 3;
  localparam int ST_PB_SIDE = 2;
  localparam int ST_PB_RDY = 1;
  localparam int ST_INT = 0;
  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] IDX_RST = 2'h0;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 32'h0000_0000;

  typedef struct packed {
    logic adpcm;
    logic wide;
    logic stereo;
  } pabt_fmt_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } pabt_req_t;
endpackage
`default_nettype wire

// ==== rtl/pabt_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module pabt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic in_valid, // write request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // not empty
  input wire logic out_ready, // read accept
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule // pabt_fifo
`default_nettype wire

// ==== rtl/pabt_tracker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pabt_tracker (
  input wire logic clk, // clock
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable
  input wire pabt_pkg::pabt_fmt_t fmt, // sample format
  input wire logic adv, // step to next byte
  input wire logic restart, // back to first byte
  output logic [1:0] idx, // byte position
  output logic last, // on last byte of sample
  output logic half, // upper or 8-bit byte
  output logic side // left, mono or first pair
);
  logic [1:0] idx_q, idx_d;
  logic [1:0] last_idx;

  always_comb begin
    if (fmt.adpcm || (fmt.wide && fmt.stereo)) begin
      last_idx = 2'h3;
    end else if (fmt.wide || fmt.stereo) begin
      last_idx = 2'h1;
    end else begin
      last_idx = 2'h0;
    end
    if (fmt.adpcm || fmt.wide) begin
      half = idx_q[0];
      side = ~(idx_q[1] & (fmt.adpcm | fmt.stereo));
    end else begin
      half = 1'b1;
      side = ~(idx_q[0] & fmt.stereo);
    end
    idx_d = idx_q;
    if (restart) begin
      idx_d = pabt_pkg::IDX_RST;
    end else if (adv && idx_q != last_idx) begin
      idx_d = idx_q + 2'h1;
    end
  end

  assign idx = idx_q;
  assign last = (idx_q == last_idx);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q <= pabt_pkg::IDX_RST;
    end else if (ce) begin
      idx_q <= idx_d;
    end
  end
endmodule // pabt_tracker
`default_nettype wire

// ==== rtl/pabt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - playback half bit: lower/1st/3rd reads 0
// R2 - late sample sets the error bit
// R3 - capture overrun or playback underrun sets error
// R4 - capture ready is 1 only for fresh data
// R5 - capture side bit: right/3-4 is 0
// R6 - adpcm side bit splits byte pairs
// R7 - capture half bit: lower/1st/3rd reads 0
// R8 - both ready bits are active high
// R9 - data writes play, data reads capture
// R10 - idle: data writes ignored, reads 80h
// R11 - data read steps capture byte tracker
// R12 - status shows next capture byte position
// R13 - capture tracker holds on last byte
// R14 - status read plus new sample restarts capture
// R15 - data write steps playback byte tracker
// R16 - writes after full sample are dropped
// R17 - playback restarts after status read and push
// R18 - playback ready low while sample is pending
module pabt_top (
  input wire logic clk, // 40 MHz clock
  input wire logic sys_rst, // async reset, high
  input wire logic ce, // clock enable
  input wire pabt_pkg::pabt_req_t host_req, // host strobes, address, data
  output logic [7:0] host_rdata, // read data, registered
  input wire pabt_pkg::pabt_fmt_t fmt_play, // playback format
  input wire pabt_pkg::pabt_fmt_t fmt_cap, // capture format
  input wire logic dev_idle, // initializing or powered down
  input wire logic play_en, // playback enabled
  input wire logic cap_en, // capture enabled
  output logic pb_smp_valid, // playback sample available
  input wire logic pb_smp_ready, // converter takes a sample
  output logic [31:0] pb_smp_data, // playback sample
  input wire logic cap_smp_valid, // converter offers a sample
  output logic cap_smp_ready, // capture fifo has room
  input wire logic [31:0] cap_smp_data // captured sample
);
  typedef enum logic [1:0] {PB_FILL, PB_PUSH, PB_WAIT} pabt_pb_st_t;
  typedef enum logic [1:0] {CAP_EMPTY, CAP_FRESH, CAP_STALE} pabt_cap_st_t;

  // ----------------------------------------------------------------
  // host access decode
  // ----------------------------------------------------------------
  logic rd_stat, wr_stat, rd_data, wr_data;
  assign rd_stat = ce & host_req.rd & (host_req.addr == pabt_pkg::ADDR_STATUS);
  assign wr_stat = ce & host_req.wr & (host_req.addr == pabt_pkg::ADDR_STATUS);
  // R9 shared data address
  assign rd_data = ce & host_req.rd & (host_req.addr == pabt_pkg::ADDR_DATA) & ~dev_idle;
  // R10 idle drops data writes
  assign wr_data = ce & host_req.wr & (host_req.addr == pabt_pkg::ADDR_DATA) & ~dev_idle;

  // ----------------------------------------------------------------
  // playback byte assembly
  // ----------------------------------------------------------------
  pabt_pb_st_t pb_st_q, pb_st_d;
  logic [31:0] pb_buf_q, pb_buf_d;
  logic pb_seen_q, pb_seen_d;
  logic pb_adv, pb_restart, pb_last, pb_half, pb_side, pb_in_ready;
  logic [1:0] pb_idx;

  pabt_tracker u_pb_trk (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .fmt(fmt_play),
    .adv(pb_adv),
    .restart(pb_restart),
    .idx(pb_idx),
    .last(pb_last),
    .half(pb_half),
    .side(pb_side)
  );

  always_comb begin
    pb_st_d = pb_st_q;
    pb_buf_d = pb_buf_q;
    pb_seen_d = pb_seen_q;
    pb_adv = 1'b0;
    pb_restart = 1'b0;
    case (pb_st_q)
      PB_FILL: begin
        // R15 write steps tracker
        if (wr_data) begin
          pb_buf_d[{pb_idx, 3'b000} +: 8] = host_req.wdata;
          if (pb_last) begin
            pb_st_d = PB_PUSH;
          end else begin
            pb_adv = 1'b1;
          end
        end
      end
      // R16 no byte lands outside fill
      PB_PUSH: begin
        if (pb_in_ready) begin
          pb_st_d = PB_WAIT;
        end
      end
      // R17 restart after push and status read
      PB_WAIT: begin
        if (pb_seen_q) begin
          pb_st_d = PB_FILL;
          pb_restart = 1'b1;
          pb_seen_d = 1'b0;
        end
      end
      default: begin
        pb_st_d = PB_FILL;
      end
    endcase
    // a status read counts only while the next state is push or wait
    if (rd_stat && pb_st_d != PB_FILL) begin
      pb_seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pb_st_q <= PB_FILL;
      pb_buf_q <= pabt_pkg::SAMPLE_RST;
      pb_seen_q <= 1'b0;
    end else if (ce) begin
      pb_st_q <= pb_st_d;
      pb_buf_q <= pb_buf_d;
      pb_seen_q <= pb_seen_d;
    end
  end

  pabt_fifo #(.WIDTH(pabt_pkg::SAMPLE_W), .DEPTH(pabt_pkg::FIFO_DEPTH)) u_pb_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(pb_st_q == PB_PUSH),
    .in_ready(pb_in_ready),
    .in_data(pb_buf_q),
    .out_valid(pb_smp_valid),
    .out_ready(pb_smp_ready),
    .out_data(pb_smp_data)
  );

  // ----------------------------------------------------------------
  // capture byte delivery
  // ----------------------------------------------------------------
  pabt_cap_st_t cap_st_q, cap_st_d;
  logic [31:0] cap_smp_q, cap_smp_d, cap_head;
  logic cap_seen_q, cap_seen_d;
  logic cap_adv, cap_load, cap_last, cap_half, cap_side, cap_head_valid;
  logic [1:0] cap_idx;

  pabt_fifo #(.WIDTH(pabt_pkg::SAMPLE_W), .DEPTH(pabt_pkg::FIFO_DEPTH)) u_cap_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(cap_smp_valid),
    .in_ready(cap_smp_ready),
    .in_data(cap_smp_data),
    .out_valid(cap_head_valid),
    .out_ready(cap_load),
    .out_data(cap_head)
  );

  pabt_tracker u_cap_trk (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .fmt(fmt_cap),
    .adv(cap_adv),
    .restart(cap_load),
    .idx(cap_idx),
    .last(cap_last),
    .half(cap_half),
    .side(cap_side)
  );

  always_comb begin
    cap_st_d = cap_st_q;
    cap_smp_d = cap_smp_q;
    cap_seen_d = cap_seen_q;
    cap_adv = 1'b0;
    cap_load = 1'b0;
    case (cap_st_q)
      CAP_EMPTY: begin
        cap_load = cap_head_valid;
      end
      // R11 read steps tracker
      CAP_FRESH: begin
        if (rd_data) begin
          if (cap_last) begin
            cap_st_d = CAP_STALE;
          end else begin
            cap_adv = 1'b1;
          end
        end
      end
      // R13 hold on last byte
      CAP_STALE: begin
        if (rd_stat) begin
          cap_seen_d = 1'b1;
        end
        // R14 next sample after status read
        cap_load = cap_seen_q & cap_head_valid;
      end
      default: begin
        cap_st_d = CAP_EMPTY;
      end
    endcase
    if (cap_load) begin
      cap_st_d = CAP_FRESH;
      cap_smp_d = cap_head;
      cap_seen_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_st_q <= CAP_EMPTY;
      cap_smp_q <= pabt_pkg::SAMPLE_RST;
      cap_seen_q <= 1'b0;
    end else if (ce) begin
      cap_st_q <= cap_st_d;
      cap_smp_q <= cap_smp_d;
      cap_seen_q <= cap_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // sample error and status
  // ----------------------------------------------------------------
  logic ser_q, ser_d, underrun, overrun;
  logic pb_rdy, cap_rdy;
  logic [7:0] status;
  // R3 either path may set it
  assign underrun = play_en & pb_smp_ready & ~pb_smp_valid;
  assign overrun = cap_en & cap_smp_valid & ~cap_smp_ready;

  always_comb begin
    ser_d = ser_q;
    if (wr_stat) begin
      ser_d = 1'b0;
    end
    // R2 set wins over clear
    if (ce && (underrun || overrun)) begin
      ser_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_q <= 1'b0;
    end else if (ce) begin
      ser_q <= ser_d;
    end
  end

  // R8 active-high ready bits
  assign cap_rdy = (cap_st_q == CAP_FRESH);
  // R18 low until tracker is back at fill
  assign pb_rdy = (pb_st_q == PB_FILL);

  always_comb begin
    status = '0;
    // R5 R6 R7 R12 capture position
    status[pabt_pkg::ST_CAP_HALF] = cap_half;
    status[pabt_pkg::ST_CAP_SIDE] = cap_side;
    // R4 fresh or stale
    status[pabt_pkg::ST_CAP_RDY] = cap_rdy;
    status[pabt_pkg::ST_SER] = ser_q;
    // R1 playback position
    status[pabt_pkg::ST_PB_HALF] = pb_half;
    status[pabt_pkg::ST_PB_SIDE] = pb_side;
    status[pabt_pkg::ST_PB_RDY] = pb_rdy;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (ce && host_req.rd) begin
      case (host_req.addr)
        pabt_pkg::ADDR_STATUS: rdata_d = status;
        // R10 fixed pattern while idle
        pabt_pkg::ADDR_DATA: begin
          rdata_d = dev_idle ? pabt_pkg::IDLE_READ : cap_smp_q[{cap_idx, 3'b000} +: 8];
        end
        default: rdata_d = pabt_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= pabt_pkg::RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign host_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pb_last_write;
    wr_data && pb_st_q == PB_FILL && pb_last;
  endsequence
  sequence s_pb_pending;
    !pb_rdy [*2];
  endsequence
  sequence s_cap_last_read;
    rd_data && cap_st_q == CAP_FRESH && cap_last;
  endsequence

  chk_pb_half_bit: assert property ( // R1
    ce && pb_st_q == PB_FILL && fmt_play.wide && !fmt_play.adpcm && pb_idx == 2'h0
    |-> !status[pabt_pkg::ST_PB_HALF]) else $error("playback half bit wrong");
  chk_ser_sets: assert property ( // R2
    ce && (underrun || overrun) |=> ser_q) else $error("sample error not set");
  chk_cap_stale: assert property ( // R4
    s_cap_last_read |=> !status[pabt_pkg::ST_CAP_RDY]) else $error("capture ready stuck");
  chk_idle_pattern: assert property ( // R10
    ce && host_req.rd && host_req.addr == pabt_pkg::ADDR_DATA && dev_idle
    |=> host_rdata == 8'h80) else $error("idle read not 80h");
  chk_cap_hold: assert property ( // R13
    cap_st_q == CAP_STALE && !cap_load |=> $stable(cap_idx)) else $error("capture tracker moved");
  chk_cap_first: assert property ( // R14
    ce && cap_load |=> cap_idx == 2'h0 && cap_rdy) else $error("capture not at first byte");
  chk_pb_drop: assert property ( // R16
    pb_st_q != PB_FILL |=> $stable(pb_buf_q)) else $error("byte written after sample");
  chk_pb_ready_low: assert property ( // R18
    s_pb_last_write |=> s_pb_pending) else $error("playback ready not held low");
endmodule // pabt_top
`default_nettype wire

// ==== verification/pabt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pabt_host (
  input wire logic clk, // clock
  output pabt_pkg::pabt_req_t host_req, // strobes, address, data
  input wire logic [7:0] host_rdata // read data
);
  initial host_req = '{rd: 1'b0, wr: 1'b0, addr: 2'h0, wdata: 8'h00};
  // one strobe cycle per access; released lines flip so stale data never matches
  task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    host_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    #1 q = host_rdata;
  endtask
endmodule // pabt_host
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  pabt_pkg::pabt_req_t host_req;
  logic [7:0] host_rdata;
  logic [7:0] q;
  pabt_pkg::pabt_fmt_t fmt_play = '{adpcm: 1'b0, wide: 1'b1, stereo: 1'b0};
  pabt_pkg::pabt_fmt_t fmt_cap = '{adpcm: 1'b0, wide: 1'b0, stereo: 1'b1};
  logic dev_idle = 1'b0;
  logic play_en = 1'b1;
  logic cap_en = 1'b1;
  logic pb_smp_valid;
  logic pb_smp_ready = 1'b0;
  logic [31:0] pb_smp_data;
  logic cap_smp_valid = 1'b0;
  logic cap_smp_ready;
  logic [31:0] cap_smp_data = 32'h0000_0000;
  int num_errors = 0;
  int checks = 0;
  localparam logic [1:0] ST = pabt_pkg::ADDR_STATUS;
  localparam logic [1:0] DT = pabt_pkg::ADDR_DATA;

  always #12.5 clk = ~clk;

  pabt_top i_pabt_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .host_req(host_req),
    .host_rdata(host_rdata), .fmt_play(fmt_play), .fmt_cap(fmt_cap), .dev_idle(dev_idle),
    .play_en(play_en), .cap_en(cap_en), .pb_smp_valid(pb_smp_valid),
    .pb_smp_ready(pb_smp_ready), .pb_smp_data(pb_smp_data), .cap_smp_valid(cap_smp_valid),
    .cap_smp_ready(cap_smp_ready), .cap_smp_data(cap_smp_data));
  pabt_host i_pabt_host (.clk(clk), .host_req(host_req), .host_rdata(host_rdata));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] a);
    i_pabt_host.access(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_pabt_host.access(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    rd(a);
    cmp({24'h0, q}, {24'h0, e});
  endtask
  // valid held one cycle; with ready low this is an overrun on purpose
  task automatic push(input logic [31:0] d);
    @(posedge clk);
    cap_smp_valid <= 1'b1;
    cap_smp_data <= d;
    @(posedge clk);
    cap_smp_valid <= 1'b0;
    cap_smp_data <= ~d;
    #1;
  endtask
  task automatic pull(input int n);
    @(posedge clk);
    pb_smp_ready <= 1'b1;
    repeat (n) @(posedge clk);
    pb_smp_ready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_status;
    chk_rd(ST, 8'hc6);
    chk_rd(2'h0, 8'h00);
  endtask
  task automatic t_play;
    wr(DT, 8'h34);
    chk_rd(ST, 8'hce);
    wr(DT, 8'h12);
    wr(DT, 8'hee);
    rd(ST);
    cmp({31'h0, q[1]}, 32'h0);
    chk_rd(ST, 8'hc6);
    cmp({31'h0, pb_smp_valid}, 32'h1);
    cmp(pb_smp_data, 32'h0000_1234);
    // second ready cycle finds the fifo empty
    pull(2);
    chk_rd(ST, 8'hd6);
    wr(ST, 8'h00);
    chk_rd(ST, 8'hc6);
  endtask
  task automatic t_cap;
    push(32'h0000_bbaa);
    chk_rd(ST, 8'he6);
    chk_rd(DT, 8'haa);
    chk_rd(ST, 8'ha6);
    chk_rd(DT, 8'hbb);
    chk_rd(DT, 8'hbb);
    push(32'h0000_ddcc);
    chk_rd(ST, 8'h86);
    chk_rd(ST, 8'he6);
    chk_rd(DT, 8'hcc);
  endtask
  task automatic t_idle;
    @(posedge clk);
    dev_idle <= 1'b1;
    chk_rd(DT, 8'h80);
    wr(DT, 8'h55);
    @(posedge clk);
    dev_idle <= 1'b0;
    chk_rd(ST, 8'ha6);
    chk_rd(DT, 8'hdd);
  endtask
  task automatic t_fill;
    int n;
    n = 0;
    while (cap_smp_ready === 1'b1 && n < 12) begin
      push({16'h0, 8'h20 + 8'(n), 8'h10 + 8'(n)});
      n++;
    end
    cmp(32'(n), 32'd8);
    push(32'hffff_ffff);
    chk_rd(ST, 8'h96);
    wr(ST, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(ST);
      chk_rd(DT, 8'h10 + 8'(i));
      chk_rd(DT, 8'h20 + 8'(i));
    end
    chk_rd(ST, 8'h86);
    cmp({31'h0, cap_smp_ready}, 32'h1);
  endtask
  // four-byte compressed group on capture, a frozen write, then one on playback
  task automatic t_adpcm;
    @(posedge clk);
    fmt_play <= '{adpcm: 1'b1, wide: 1'b0, stereo: 1'b0};
    fmt_cap <= '{adpcm: 1'b1, wide: 1'b0, stereo: 1'b0};
    push(32'h4433_2211);
    chk_rd(ST, 8'h66);
    chk_rd(DT, 8'h11);
    chk_rd(ST, 8'he6);
    chk_rd(DT, 8'h22);
    chk_rd(ST, 8'h26);
    chk_rd(DT, 8'h33);
    chk_rd(ST, 8'ha6);
    chk_rd(DT, 8'h44);
    chk_rd(ST, 8'h86);
    @(posedge clk);
    ce <= 1'b0;
    wr(DT, 8'hff);
    @(posedge clk);
    ce <= 1'b1;
    chk_rd(ST, 8'h86);
    wr(DT, 8'ha1);
    chk_rd(ST, 8'h8e);
    wr(DT, 8'hb2);
    chk_rd(ST, 8'h82);
    wr(DT, 8'hc3);
    chk_rd(ST, 8'h8a);
    wr(DT, 8'hd4);
    chk_rd(ST, 8'h88);
    cmp(pb_smp_data, 32'hd4c3_b2a1);
    // playback disabled: the empty ready cycle must not flag an error
    @(posedge clk);
    play_en <= 1'b0;
    pull(2);
    chk_rd(ST, 8'h86);
    @(posedge clk);
    play_en <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_status();
    t_play();
    t_cap();
    t_idle();
    t_fill();
    t_adpcm();
    complete_run();
  end
  initial begin
    #(25 * 5000);
    num_errors++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
